// File: iskip_regs.vh
// constants for the increment-and-skip execution block
// assumes inclusion by the single design file only
`ifndef ISKIP_REGS_VH
`define ISKIP_REGS_VH
`define ISKIP_OP_SKZ 6'h0F
`define ISKIP_OP_SKNZ 6'h12
`define ISKIP_OP_MSB 15
`define ISKIP_OP_LSB 10
`define ISKIP_D_BIT 9
`define ISKIP_A_BIT 8
`define ISKIP_IDX_MAX 8'h5F
`define ISKIP_ACC_LOW_MAX 8'h7F
`define ISKIP_ACC_HIGH_BANK 4'hF
`define ISKIP_W_RST 8'h00
`define ISKIP_CNT_RST 2'h0
`endif

// File: iskip_exec.v
// increment-and-skip executor: decode, address resolve, result, skip control
// assumes one instruction word offered per I_CORE_CLK when I_INSTR_VALID, and
// file data returned combinationally for the address presented.
// Function
// - result is addressed register plus one
// - d zero writes result to working register
// - d one writes result to file
// - zero variant skips on zero result
// - skip discards prefetched word, inserts nop
// - nonzero variant skips on nonzero result
// - a zero resolves in access bank
// - a one uses bank select value
// - extended set, a zero, f<=95: indexed
// - one word; 1, 2 or 3 cycles
`timescale 1ns/10ps
`default_nettype none
`include "iskip_regs.vh"
module iskip_exec (
  // clock and reset
  input wire I_CORE_CLK,
  input wire I_RESET_N,
  // instruction stream
  input wire I_INSTR_VALID,
  input wire [15:0] I_INSTR,
  input wire I_NEXT_TWO_WORD,
  input wire I_EXT_SET_EN,
  input wire [3:0] I_BANK_SELECT_VALUE,
  input wire [11:0] I_INDEX_BASE,
  // file register read port
  input wire [7:0] I_FILE_RDATA,
  output wire [11:0] O_FILE_ADDR,
  // results
  output reg O_FILE_WE,
  output reg [11:0] O_FILE_WADDR,
  output reg [7:0] O_FILE_WDATA,
  output reg [7:0] O_WREG,
  output reg O_STATUS_WE,
  output wire O_IS_ISKIP,
  output reg O_SKIP,
  output wire O_BUSY
);
  reg [1:0] nop_cnt_q;
  reg [1:0] nop_cnt_d;
  wire [5:0] op;
  wire dsel;
  wire asel;
  wire [7:0] faddr;
  wire is_skz;
  wire is_sknz;
  wire take;
  wire [7:0] result;
  wire do_skip;
  wire skip_now;
  wire res_zero;
  wire slot_free;
  wire is_any;
  wire [1:0] drop_len;
  wire [1:0] addr_rgn;
  // carry into each incrementer bit; no carry out, so no flag can see overflow
  wire [7:0] inc_carry;
  genvar gi;

  // discard states; each code is the number of words still to drop
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_DROP_ONE = 2'h1;
  localparam [1:0] ST_DROP_TWO = 2'h2;

  // where an 8-bit operand lands in data memory
  localparam [1:0] RGN_BANKED = 2'h0;
  localparam [1:0] RGN_INDEXED = 2'h1;
  localparam [1:0] RGN_ACC_LOW = 2'h2;
  localparam [1:0] RGN_ACC_HIGH = 2'h3;

  // zero test shared by both skip conditions
  function iskip_is_zero;
    input [7:0] val;
    begin
      iskip_is_zero = (val == 8'h00);
    end
  endfunction

  // words to discard after a taken skip
  function [1:0] iskip_drop_len;
    input two_word;
    begin
      if (two_word) begin
        iskip_drop_len = ST_DROP_TWO;
      end else begin
        iskip_drop_len = ST_DROP_ONE;
      end
    end
  endfunction

  // opcode decode shared by both variants
  function [1:0] iskip_decode;
    input [5:0] opc;
    begin
      iskip_decode = {opc == `ISKIP_OP_SKNZ, opc == `ISKIP_OP_SKZ};
    end
  endfunction

  // classify 8-bit operand; indexed mode outranks the plain access bank
  function [1:0] iskip_region;
    input [7:0] f;
    input a;
    input ext;
    begin
      if (a) begin
        iskip_region = RGN_BANKED;
      end else if (ext && (f <= `ISKIP_IDX_MAX)) begin
        iskip_region = RGN_INDEXED;
      end else if (f <= `ISKIP_ACC_LOW_MAX) begin
        iskip_region = RGN_ACC_LOW;
      end else begin
        iskip_region = RGN_ACC_HIGH;
      end
    end
  endfunction

  // resolve 8-bit operand into 12-bit data address
  function [11:0] iskip_resolve;
    input [7:0] f;
    input [1:0] rgn;
    input [3:0] bank;
    input [11:0] base;
    begin
      case (rgn)
        RGN_BANKED: begin
          iskip_resolve = {bank, f};
        end
        RGN_INDEXED: begin
          // wraps in 12 bits; base near the top folds back to page zero
          iskip_resolve = base + {4'h0, f};
        end
        RGN_ACC_LOW: begin
          iskip_resolve = {4'h0, f};
        end
        default: begin
          iskip_resolve = {`ISKIP_ACC_HIGH_BANK, f};
        end
      endcase
    end
  endfunction

  assign op = I_INSTR[`ISKIP_OP_MSB:`ISKIP_OP_LSB];
  assign dsel = I_INSTR[`ISKIP_D_BIT];
  assign asel = I_INSTR[`ISKIP_A_BIT];
  assign faddr = I_INSTR[7:0];
  assign is_skz = iskip_decode(op) == 2'h1;
  assign is_sknz = iskip_decode(op) == 2'h2;
  // words arriving during a skip are discarded, not executed
  assign slot_free = (nop_cnt_q == ST_RUN);
  assign take = I_INSTR_VALID && slot_free;
  assign is_any = is_skz || is_sknz;
  assign O_IS_ISKIP = take && is_any;
  assign O_BUSY = !slot_free;
  // access bank, bank select, indexed offset
  assign addr_rgn = iskip_region(faddr, asel, I_EXT_SET_EN);
  assign O_FILE_ADDR = iskip_resolve(faddr, addr_rgn, I_BANK_SELECT_VALUE, I_INDEX_BASE);
  assign inc_carry[0] = 1'b1;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_inc
      assign result[gi] = I_FILE_RDATA[gi] ^ inc_carry[gi];
      if (gi < 7) begin : g_carry
        assign inc_carry[gi + 1] = I_FILE_RDATA[gi] & inc_carry[gi];
      end
    end
  endgenerate

  assign res_zero = iskip_is_zero(result);
  assign do_skip = (is_skz && res_zero) || (is_sknz && !res_zero);
  assign skip_now = O_IS_ISKIP && do_skip;
  assign drop_len = iskip_drop_len(I_NEXT_TWO_WORD);

  // one or two inserted nop cycles
  always @* begin
    nop_cnt_d = nop_cnt_q;
    case (nop_cnt_q)
      ST_RUN: begin
        if (skip_now) begin
          nop_cnt_d = drop_len;
        end
      end
      ST_DROP_ONE: begin
        // only valid words count; a fetch stall keeps the drop pending
        if (I_INSTR_VALID) begin
          nop_cnt_d = ST_RUN;
        end
      end
      ST_DROP_TWO: begin
        if (I_INSTR_VALID) begin
          nop_cnt_d = ST_DROP_ONE;
        end
      end
      default: begin
        nop_cnt_d = ST_RUN;
      end
    endcase
  end

  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      nop_cnt_q <= `ISKIP_CNT_RST;
    end else begin
      nop_cnt_q <= nop_cnt_d;
    end
  end

  // flags untouched
  // kept as a port so the core's flag mux needs no special case
  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_STATUS_WE <= 1'b0;
    end else begin
      O_STATUS_WE <= 1'b0;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SKIP <= 1'b0;
    end else begin
      O_SKIP <= skip_now;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FILE_WE <= 1'b0;
    end else begin
      O_FILE_WE <= O_IS_ISKIP && dsel;
    end
  end

  // address and data hold after the strobe; only the strobe is a pulse
  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FILE_WADDR <= 12'h000;
      O_FILE_WDATA <= 8'h00;
    end else if (O_IS_ISKIP && dsel) begin
      O_FILE_WADDR <= O_FILE_ADDR;
      O_FILE_WDATA <= result;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_WREG <= `ISKIP_W_RST;
    end else if (O_IS_ISKIP && !dsel) begin
      O_WREG <= result;
    end
  end
endmodule // iskip_exec
`default_nettype wire

// File: iskip_exec_monitor.sv
// assertions on the increment-and-skip executor ports
// assumes binding into iskip_exec
`timescale 1ns/10ps
`default_nettype none
module iskip_monitor (
  input wire I_CORE_CLK, I_RESET_N, I_INSTR_VALID, I_NEXT_TWO_WORD, O_FILE_WE,
  input wire O_STATUS_WE, O_SKIP, O_BUSY, O_IS_ISKIP, I_EXT_SET_EN,
  input wire [15:0] I_INSTR,
  input wire [3:0] I_BANK_SELECT_VALUE,
  input wire [7:0] I_FILE_RDATA, O_FILE_WDATA, O_WREG,
  input wire [11:0] O_FILE_ADDR, O_FILE_WADDR, I_INDEX_BASE
);
  wire t = I_INSTR_VALID && !O_BUSY && (I_INSTR[15:10] == 6'h0F || I_INSTR[15:10] == 6'h12);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  AST_RES: assert property (t |=> (O_FILE_WE ? O_FILE_WDATA : O_WREG) ==
    $past(I_FILE_RDATA) + 8'h01) else $error("wrong sum");
  AST_DST: assert property (t |=> O_FILE_WE == $past(I_INSTR[9]))
    else $error("wrong target");
  AST_SKP: assert property (t |=> O_SKIP == ($past(I_INSTR[10]) ==
    ($past(I_FILE_RDATA) == 8'hFF))) else $error("wrong skip");
  AST_NOP: assert property (O_SKIP |-> O_BUSY) else $error("no discard");
  AST_BSV: assert property (t && I_INSTR[8] |->
    O_FILE_ADDR == {I_BANK_SELECT_VALUE, I_INSTR[7:0]}) else $error("wrong bank");
  AST_CYC: assert property (O_SKIP && I_INSTR_VALID |=>
    O_BUSY == $past(I_NEXT_TWO_WORD, 2)) else $error("wrong skip length");
  AST_STS: assert property (!O_STATUS_WE) else $error("flags written");
  AST_IGN: assert property (!t |=> !O_FILE_WE && !O_SKIP) else $error("stray");
  AST_ISK: assert property (O_IS_ISKIP == t) else $error("wrong decode");
  AST_WAD: assert property (t && I_INSTR[9] |=> O_FILE_WADDR == $past(O_FILE_ADDR))
    else $error("wrong write address");
  AST_ACC: assert property (t && !I_INSTR[8] && (!I_EXT_SET_EN || I_INSTR[7:0] > 8'h5F) |->
    O_FILE_ADDR == {(I_INSTR[7] ? 4'hF : 4'h0), I_INSTR[7:0]}) else $error("wrong access");
  AST_IDX: assert property (t && !I_INSTR[8] && I_EXT_SET_EN && I_INSTR[7:0] <= 8'h5F |->
    O_FILE_ADDR == I_INDEX_BASE + {4'h0, I_INSTR[7:0]}) else $error("wrong index");
endmodule // iskip_monitor
bind iskip_exec iskip_monitor mon (.*);
`default_nettype wire

// File: testbench.sv
// random instruction stream with checks for the executor
// assumes iskip_exec with its bound monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  reg I_CORE_CLK = 0, I_RESET_N = 0, I_INSTR_VALID = 0, I_NEXT_TWO_WORD = 0, I_EXT_SET_EN = 0;
  reg [15:0] I_INSTR = 16'h0000, w;
  reg [3:0] I_BANK_SELECT_VALUE = 4'h0;
  reg [11:0] I_INDEX_BASE = 12'h000;
  reg [7:0] I_FILE_RDATA = 8'h00, v;
  wire O_FILE_WE, O_STATUS_WE, O_IS_ISKIP, O_SKIP, O_BUSY;
  wire [11:0] O_FILE_ADDR, O_FILE_WADDR;
  wire [7:0] O_FILE_WDATA, O_WREG;
  reg [31:0] r;
  reg tk = 0;
  integer seed = 31, err_total = 0, n_tests = 0, cyc = 0, i;
  iskip_exec dut (.*);
  function exp_skip(input [15:0] w, input [7:0] v);
    exp_skip = w[10] ~^ (v == 8'hFF);
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial forever #10 I_CORE_CLK = ~I_CORE_CLK;
  always @(posedge I_CORE_CLK) begin
    cyc = cyc + 1;
    if (cyc == 900) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(negedge I_CORE_CLK);
    I_RESET_N = 1;
    for (i = 0; i < 800; i = i + 1) begin
      n_tests = n_tests + 1;
      if (tk && {O_SKIP, O_FILE_WE, (w[9] ? O_FILE_WDATA : O_WREG)} !==
          {exp_skip(w, v), w[9], v + 8'h01}) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: wrong result or skip", $time);
      end
      r = $random(seed);
      {I_NEXT_TWO_WORD, I_EXT_SET_EN, I_INDEX_BASE} = {r[31:30], r[27:16]};
      I_INSTR_VALID = r[28] | r[29];
      I_BANK_SELECT_VALUE = r[15:12];
      // corner values FF and 00 give zero and one
      I_FILE_RDATA = r[11] ? 8'hFF : (r[10] ? 8'h00 : r[19:12]);
      I_INSTR = {r[20] ? 6'h0F : (r[21] ? 6'h12 : r[27:22]), r[9:0]};
      #1;
      w = I_INSTR;
      v = I_FILE_RDATA;
      tk = I_INSTR_VALID && !O_BUSY && (w[15:10] == 6'h0F || w[15:10] == 6'h12);
      @(negedge I_CORE_CLK);
    end
    $display("random stream done");
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
